// >>> rtl/arf_filter.sv
// conversion result accumulator, filter, error and threshold stage
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Operation
// - running sum is a 16-bit accumulator read as high and low bytes
// - in accumulate, average, burst and low-pass modes every trigger event adds the new result to the sum
// - a sum passing 65535 sets the overflow flag in status
// - each added sample increments the counter, compared with repeat count; here the counter holds at 255
// - clear bit clears sum, overflow and counter; hardware drops bit after
// - on the rc clock clearing takes five of its cycles
// - sum shifted right by shift field; accumulate mode copies it to filtered
// - basic mode accumulates nothing but still compares the error
// - accumulate mode adds, counts, updates filtered and compares every sample
// - result format never changes right-justified sum contents
// - average mode accumulates each sample, compares once count reaches repeat
// - burst average retriggers conversions itself until count reaches repeat; here only while continuous is off
// - low-pass mode filters with cut-off by shift, compares at repeat count
// - each result latched at end of conversion and held for computation
// - error computed by the calculation chosen in the select field
// - error compared with upper and lower limits, setting their flags
// - threshold mode picks never, below, above, between, outside, always
// - met condition at a comparison point sets threshold flag
// - all threshold comparisons are signed
// - overflow flag set forces a threshold interrupt
module arf_filter
  import arf_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // converter core
  input wire logic [15:0] conv_result,
  input wire logic conv_done,
  input wire logic [15:0] cvd_result,
  input wire logic on_rc_clock,
  input wire logic rc_clock_tick,
  input wire logic continuous_enable,
  output logic retrigger,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // status
  output logic threshold_irq_flag,
  output logic sum_overflow_flag
);
  logic [15:0] running_sum_q;
  logic [7:0] sample_counter_q;
  logic [7:0] repeat_count_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_three_q;
  logic [15:0] filtered_result_q;
  logic [15:0] prev_filtered_q;
  logic [15:0] error_value_q;
  logic [15:0] upper_limit_q;
  logic [15:0] lower_limit_q;
  logic [15:0] setpoint_q;
  logic [15:0] sample_q;
  logic [15:0] prev_sample_q;
  logic sum_overflow_q;
  logic above_upper_q;
  logic below_lower_q;
  logic tif_q;
  logic clear_busy_q;
  logic [2:0] clear_cnt_q;
  logic [7:0] rdata_q;
  logic stage_q;
  logic [2:0] mode;
  logic [2:0] shift;
  arf_tmd_type tmd;
  logic [2:0] calc;
  logic mode_acc;
  logic [16:0] sum_ext;
  logic [15:0] sum_next;
  logic [15:0] shifted;
  logic [15:0] lpf_next;
  logic [15:0] flt_next;
  logic [7:0] count_next;
  logic compare_now;
  logic [15:0] err_next;
  logic lt_lower;
  logic gt_upper;
  logic cond_met;
  logic clear_done;

  assign mode = ctrl_two_q[ARF_MODE_LSB +: 3];
  assign shift = ctrl_two_q[ARF_SHIFT_LSB +: 3];
  assign tmd = arf_tmd_type'(ctrl_three_q[ARF_TMD_LSB +: 3]);
  assign calc = ctrl_three_q[ARF_CALC_LSB +: 3];
  // codes above low-pass fall back to basic
  assign mode_acc = (mode >= 3'(ARF_MD_ACCUM)) && (mode <= 3'(ARF_MD_LPF));

  // stage 0 latches, stage 1 computes from the latched sample
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_q <= ARF_RST_WORD;
      prev_sample_q <= ARF_RST_WORD;
      stage_q <= 1'b0;
    end else if (ce) begin
      stage_q <= conv_done;
      if (conv_done) begin
        sample_q <= conv_result;
        prev_sample_q <= sample_q;
      end
    end
  end

  // sum always right-justified; format selection is not seen here
  assign sum_ext = {1'b0, running_sum_q} + {1'b0, sample_q};
  assign sum_next = sum_ext[15:0];
  assign shifted = sum_next >> shift;
  // first-order low-pass: f += (x - f) >> shift
  assign lpf_next = 16'(filtered_result_q + 16'($signed(sample_q - filtered_result_q) >>> shift));
  assign flt_next = (mode == 3'(ARF_MD_LPF)) ? lpf_next : shifted;
  assign count_next = (sample_counter_q == 8'hff) ? sample_counter_q : 8'(sample_counter_q + 8'h01);
  always_comb begin
    compare_now = 1'b0;
    case (mode)
      3'(ARF_MD_ACCUM): compare_now = 1'b1;
      3'(ARF_MD_AVG), 3'(ARF_MD_BURST), 3'(ARF_MD_LPF): compare_now = count_next >= repeat_count_q;
      default: compare_now = 1'b1;
    endcase
  end

  always_comb begin
    err_next = ARF_RST_WORD;
    case (arf_calc_type'(calc))
      ARF_EC_DERIV: err_next = 16'(sample_q - prev_sample_q);
      ARF_EC_CVD: err_next = cvd_result;
      ARF_EC_RES_SET: err_next = 16'(sample_q - setpoint_q);
      ARF_EC_RES_FLT: err_next = 16'(sample_q - flt_next);
      ARF_EC_FLT_DERIV: err_next = 16'(flt_next - filtered_result_q);
      ARF_EC_FLT_SET: err_next = 16'(flt_next - setpoint_q);
      default: err_next = ARF_RST_WORD;
    endcase
  end

  assign lt_lower = $signed(err_next) < $signed(lower_limit_q);
  assign gt_upper = $signed(err_next) > $signed(upper_limit_q);
  always_comb begin
    cond_met = 1'b0;
    case (tmd)
      ARF_TM_NEVER: cond_met = 1'b0;
      ARF_TM_BELOW_LOW: cond_met = lt_lower;
      ARF_TM_ATLEAST_LOW: cond_met = !lt_lower;
      ARF_TM_BETWEEN: cond_met = !lt_lower && !gt_upper;
      ARF_TM_OUTSIDE: cond_met = lt_lower || gt_upper;
      ARF_TM_ATMOST_UP: cond_met = !gt_upper;
      ARF_TM_ABOVE_UP: cond_met = gt_upper;
      ARF_TM_ALWAYS: cond_met = 1'b1;
      default: cond_met = 1'b0;
    endcase
  end

  // clear sequencer; on the rc clock it waits five rc ticks
  assign clear_done = clear_busy_q && (!on_rc_clock || (rc_clock_tick && clear_cnt_q == 3'h0));
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_busy_q <= 1'b0;
      clear_cnt_q <= 3'h0;
    end else if (ce) begin
      if (clear_done) begin
        clear_busy_q <= 1'b0;
      end else if (reg_write && reg_addr == ARF_ADDR_CTRL_TWO && reg_wdata[ARF_CLEAR_BIT]) begin
        clear_busy_q <= 1'b1;
        clear_cnt_q <= ARF_CLEAR_CNT_INIT;
      end else if (clear_busy_q && rc_clock_tick) begin
        clear_cnt_q <= 3'(clear_cnt_q - 3'h1);
      end
    end
  end

  // accumulation; a sample landing with the clear completion is dropped by the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      running_sum_q <= ARF_RST_WORD;
      sample_counter_q <= ARF_RST_BYTE;
      sum_overflow_q <= 1'b0;
      filtered_result_q <= ARF_RST_WORD;
      prev_filtered_q <= ARF_RST_WORD;
    end else if (ce) begin
      if (clear_done) begin
        running_sum_q <= ARF_RST_WORD;
        sample_counter_q <= ARF_RST_BYTE;
        sum_overflow_q <= 1'b0;
      end else if (stage_q && mode_acc) begin
        running_sum_q <= sum_next;
        sample_counter_q <= count_next;
        prev_filtered_q <= filtered_result_q;
        filtered_result_q <= flt_next;
        if (sum_ext[16]) begin
          sum_overflow_q <= 1'b1;
        end
      end
    end
  end

  // error and threshold flags; hardware set beats software clear of the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      error_value_q <= ARF_RST_WORD;
      above_upper_q <= 1'b0;
      below_lower_q <= 1'b0;
      tif_q <= 1'b0;
    end else if (ce) begin
      if (stage_q && compare_now) begin
        error_value_q <= err_next;
        above_upper_q <= gt_upper;
        below_lower_q <= lt_lower;
      end
      if (stage_q && compare_now && (cond_met || sum_overflow_q || (mode_acc && sum_ext[16]))) begin
        tif_q <= 1'b1;
      end else if (reg_write && reg_addr == ARF_ADDR_STATUS && !reg_wdata[ARF_STAT_TIF_BIT]) begin
        tif_q <= 1'b0;
      end
    end
  end

  // with continuous off, burst mode keeps conversions going until the counter reaches repeat
  assign retrigger = stage_q && (mode == 3'(ARF_MD_BURST)) && (count_next < repeat_count_q)
                     && !continuous_enable;

  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_two_q <= ARF_RST_BYTE;
      ctrl_three_q <= ARF_RST_BYTE;
      repeat_count_q <= ARF_RST_BYTE;
      upper_limit_q <= ARF_RST_WORD;
      lower_limit_q <= ARF_RST_WORD;
      setpoint_q <= ARF_RST_WORD;
    end else if (ce && reg_write) begin
      case (reg_addr)
        ARF_ADDR_CTRL_TWO: ctrl_two_q <= {1'b0, reg_wdata[6:0]};
        ARF_ADDR_CTRL_THREE: ctrl_three_q <= reg_wdata;
        ARF_ADDR_REPEAT: repeat_count_q <= reg_wdata;
        ARF_ADDR_UTH_LOW: upper_limit_q[7:0] <= reg_wdata;
        ARF_ADDR_UTH_HIGH: upper_limit_q[15:8] <= reg_wdata;
        ARF_ADDR_LTH_LOW: lower_limit_q[7:0] <= reg_wdata;
        ARF_ADDR_LTH_HIGH: lower_limit_q[15:8] <= reg_wdata;
        ARF_ADDR_SETPOINT_LOW: setpoint_q[7:0] <= reg_wdata;
        ARF_ADDR_SETPOINT_HIGH: setpoint_q[15:8] <= reg_wdata;
        default: ctrl_two_q <= ctrl_two_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= ARF_RST_BYTE;
    end else if (ce) begin
      rdata_q <= ARF_RST_BYTE;
      if (reg_read) begin
        case (reg_addr)
          ARF_ADDR_ACC_LOW: rdata_q <= running_sum_q[7:0];
          ARF_ADDR_ACC_HIGH: rdata_q <= running_sum_q[15:8];
          ARF_ADDR_CTRL_TWO: rdata_q <= {clear_busy_q, ctrl_two_q[6:0]};
          ARF_ADDR_CTRL_THREE: rdata_q <= ctrl_three_q;
          ARF_ADDR_STATUS: rdata_q <= {3'h0, clear_busy_q, tif_q, above_upper_q, below_lower_q, sum_overflow_q};
          ARF_ADDR_REPEAT: rdata_q <= repeat_count_q;
          ARF_ADDR_COUNT: rdata_q <= sample_counter_q;
          ARF_ADDR_FLT_LOW: rdata_q <= filtered_result_q[7:0];
          ARF_ADDR_FLT_HIGH: rdata_q <= filtered_result_q[15:8];
          ARF_ADDR_ERR_LOW: rdata_q <= error_value_q[7:0];
          ARF_ADDR_ERR_HIGH: rdata_q <= error_value_q[15:8];
          ARF_ADDR_UTH_LOW: rdata_q <= upper_limit_q[7:0];
          ARF_ADDR_UTH_HIGH: rdata_q <= upper_limit_q[15:8];
          ARF_ADDR_LTH_LOW: rdata_q <= lower_limit_q[7:0];
          ARF_ADDR_LTH_HIGH: rdata_q <= lower_limit_q[15:8];
          ARF_ADDR_SETPOINT_LOW: rdata_q <= setpoint_q[7:0];
          ARF_ADDR_SETPOINT_HIGH: rdata_q <= setpoint_q[15:8];
          default: rdata_q <= ARF_RST_BYTE;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign threshold_irq_flag = tif_q;
  assign sum_overflow_flag = sum_overflow_q;

  a_sum_adds: assert property (@(posedge clk) disable iff (rst)
    ce && stage_q && mode_acc && !clear_done |=> running_sum_q == $past(sum_next))
    else $error("sum did not take the new sample");
  a_ovf_sets: assert property (@(posedge clk) disable iff (rst)
    ce && stage_q && mode_acc && sum_ext[16] && !clear_done |=> sum_overflow_q)
    else $error("overflow flag not set on carry");
  a_count_incr: assert property (@(posedge clk) disable iff (rst)
    ce && stage_q && mode_acc && !clear_done && sample_counter_q != 8'hff
    |=> sample_counter_q == $past(sample_counter_q) + 8'h01)
    else $error("counter did not advance");
  a_clear_all: assert property (@(posedge clk) disable iff (rst)
    ce && clear_done |=> running_sum_q == 16'h0000 && sample_counter_q == 8'h00 && !sum_overflow_q)
    else $error("clear left state behind");
  a_clear_fast: assert property (@(posedge clk) disable iff (rst)
    ce && clear_busy_q && !on_rc_clock |=> !clear_busy_q)
    else $error("clear bit stuck");
  a_basic_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !mode_acc && !clear_done |=> running_sum_q == $past(running_sum_q))
    else $error("basic mode accumulated");
  a_tif_ovf: assert property (@(posedge clk) disable iff (rst)
    ce && stage_q && compare_now && sum_overflow_q |=> tif_q)
    else $error("overflow did not raise threshold flag");
  a_tif_never: assert property (@(posedge clk) disable iff (rst)
    ce && !tif_q && stage_q && tmd == ARF_TM_NEVER && !sum_overflow_q && !(mode_acc && sum_ext[16])
    |=> !tif_q)
    else $error("never mode raised flag");
  a_avg_gate: assert property (@(posedge clk) disable iff (rst)
    ce && stage_q && mode == 3'(ARF_MD_AVG) && count_next < repeat_count_q
    |=> error_value_q == $past(error_value_q))
    else $error("average compared early");
endmodule // arf_filter

// >>> rtl/arf_pkg.sv
// constants and types for the conversion result filter and threshold stage
package arf_pkg;
  // register offsets
  localparam logic [7:0] ARF_ADDR_ACC_LOW = 8'h00;
  localparam logic [7:0] ARF_ADDR_ACC_HIGH = 8'h01;
  localparam logic [7:0] ARF_ADDR_CTRL_TWO = 8'h02;
  localparam logic [7:0] ARF_ADDR_CTRL_THREE = 8'h03;
  localparam logic [7:0] ARF_ADDR_STATUS = 8'h04;
  localparam logic [7:0] ARF_ADDR_REPEAT = 8'h05;
  localparam logic [7:0] ARF_ADDR_COUNT = 8'h06;
  localparam logic [7:0] ARF_ADDR_FLT_LOW = 8'h07;
  localparam logic [7:0] ARF_ADDR_FLT_HIGH = 8'h08;
  localparam logic [7:0] ARF_ADDR_ERR_LOW = 8'h09;
  localparam logic [7:0] ARF_ADDR_ERR_HIGH = 8'h0a;
  localparam logic [7:0] ARF_ADDR_UTH_LOW = 8'h0b;
  localparam logic [7:0] ARF_ADDR_UTH_HIGH = 8'h0c;
  localparam logic [7:0] ARF_ADDR_LTH_LOW = 8'h0d;
  localparam logic [7:0] ARF_ADDR_LTH_HIGH = 8'h0e;
  localparam logic [7:0] ARF_ADDR_SETPOINT_LOW = 8'h0f;
  localparam logic [7:0] ARF_ADDR_SETPOINT_HIGH = 8'h10;
  // control two fields: mode [2:0], shift [6:4], clear bit 7
  localparam int ARF_MODE_LSB = 0;
  localparam int ARF_SHIFT_LSB = 4;
  localparam int ARF_CLEAR_BIT = 7;
  // control three fields: threshold mode [2:0], error select [6:4]
  localparam int ARF_TMD_LSB = 0;
  localparam int ARF_CALC_LSB = 4;
  // status bits
  localparam int ARF_STAT_OVF_BIT = 0;
  localparam int ARF_STAT_LOWER_BIT = 1;
  localparam int ARF_STAT_UPPER_BIT = 2;
  localparam int ARF_STAT_TIF_BIT = 3;
  localparam int ARF_STAT_CLRBUSY_BIT = 4;
  // reset values
  localparam logic [7:0] ARF_RST_BYTE = 8'h00;
  localparam logic [15:0] ARF_RST_WORD = 16'h0000;
  // clearing takes five cycles of the dedicated rc clock
  localparam int ARF_CLEAR_RC_CYCLES = 5;
  localparam logic [2:0] ARF_CLEAR_CNT_INIT = 3'(ARF_CLEAR_RC_CYCLES - 1);

  typedef enum logic [2:0] {
    ARF_MD_BASIC = 3'h0, ARF_MD_ACCUM = 3'h1, ARF_MD_AVG = 3'h2,
    ARF_MD_BURST = 3'h3, ARF_MD_LPF = 3'h4
  } arf_mode_type;

  typedef enum logic [2:0] {
    ARF_TM_NEVER = 3'h0, ARF_TM_BELOW_LOW = 3'h1, ARF_TM_ATLEAST_LOW = 3'h2, ARF_TM_BETWEEN = 3'h3,
    ARF_TM_OUTSIDE = 3'h4, ARF_TM_ATMOST_UP = 3'h5, ARF_TM_ABOVE_UP = 3'h6, ARF_TM_ALWAYS = 3'h7
  } arf_tmd_type;

  typedef enum logic [2:0] {
    ARF_EC_DERIV = 3'h0, ARF_EC_CVD = 3'h1, ARF_EC_RES_SET = 3'h2, ARF_EC_RES_FLT = 3'h4,
    ARF_EC_FLT_DERIV = 3'h5, ARF_EC_FLT_SET = 3'h6
  } arf_calc_type;
endpackage

// >>> verif/arf_conv_model.sv
// behavioural converter core delivering conversion results
`timescale 1ns/1ps
module arf_conv_model #(
  parameter int DLY = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion request
  input wire logic start,
  input wire logic [15:0] value,
  // result delivery
  output logic [15:0] conv_result,
  output logic conv_done
);
  int cnt_q;
  logic [15:0] val_q;
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    // result bus is only valid with done, so it toggles otherwise
    conv_result <= ~conv_result;
    if (rst) begin
      cnt_q <= 0;
      conv_result <= 16'h0000;
    end else if (cnt_q == 0 && start) begin
      cnt_q <= DLY;
      val_q <= value;
    end else if (cnt_q == 1) begin
      cnt_q <= 0;
      conv_done <= 1'b1;
      conv_result <= val_q;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule // arf_conv_model

// >>> verif/tb_adc_result_filter_threshold.sv
// self-checking bench for the result filter and threshold stage
`timescale 1ns/1ps
module tb_adc_result_filter_threshold
  import arf_pkg::*;
;
  logic clk, rst = 1'b1, ce = 1'b1, go = 1'b0, on_rc = 1'b0, tick = 1'b0, cont = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, retrig, conv_done, tif, ovf;
  logic [15:0] conv_val = 16'h0000, cvd_result = 16'h0000, conv_result, rd_w;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_q;
  int bad_count = 0, compares = 0, cycles = 0, retrig_n = 0;

  // burst retriggers reach the core model like a software start
  arf_conv_model u_arf_conv_model (.clk(clk), .rst(rst), .start(go | retrig), .value(conv_val),
    .conv_result(conv_result), .conv_done(conv_done));
  arf_filter u_arf_filter (.clk(clk), .rst(rst), .ce(ce), .conv_result(conv_result), .conv_done(conv_done),
    .cvd_result(cvd_result), .on_rc_clock(on_rc), .rc_clock_tick(tick), .continuous_enable(cont),
    .retrigger(retrig), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .threshold_irq_flag(tif), .sum_overflow_flag(ovf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (retrig === 1'b1) retrig_n <= retrig_n + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  // no latching in the design, so low and high bytes are two reads
  task automatic rd16(input logic [7:0] a);
    rd(a);
    rd_w[7:0] = rd_q;
    rd(a + 8'h01);
    rd_w[15:8] = rd_q;
  endtask

  task automatic conv(input logic [15:0] v);
    int n;
    n = 0;
    @(posedge clk);
    conv_val <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (conv_done !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic t_accum;
    rd(ARF_ADDR_STATUS);
    chk(16'(rd_q), 16'h0000);
    wr(ARF_ADDR_CTRL_THREE, 8'h00);
    wr(ARF_ADDR_CTRL_TWO, 8'h11);
    conv(16'h0100);
    conv(16'h0203);
    conv(16'h0005);
    rd16(ARF_ADDR_ACC_LOW);
    chk(rd_w, 16'h0308);
    rd(ARF_ADDR_COUNT);
    chk(16'(rd_q), 16'h0003);
    rd16(ARF_ADDR_FLT_LOW);
    chk(rd_w, 16'h0184);
    $display("accumulate test done");
  endtask

  task automatic t_ovf_clear;
    conv(16'hffff);
    chk(16'(ovf), 16'h0001);
    chk(16'(tif), 16'h0001);
    wr(ARF_ADDR_CTRL_TWO, 8'h91);
    rd(ARF_ADDR_CTRL_TWO);
    chk(16'(rd_q), 16'h0011);
    rd16(ARF_ADDR_ACC_LOW);
    chk(rd_w, 16'h0000);
    rd(ARF_ADDR_COUNT);
    chk(16'(rd_q), 16'h0000);
    chk(16'(ovf), 16'h0000);
    $display("overflow and clear test done");
  endtask

  task automatic t_thresh;
    // expected flag per threshold mode for an error of -8 within -16..16
    logic [7:0] exp_t;
    exp_t = 8'hac;
    wr(ARF_ADDR_CTRL_TWO, 8'h00);
    wr(ARF_ADDR_SETPOINT_LOW, 8'h08);
    wr(ARF_ADDR_UTH_LOW, 8'h10);
    wr(ARF_ADDR_LTH_LOW, 8'hf0);
    wr(ARF_ADDR_LTH_HIGH, 8'hff);
    for (int t = 0; t < 8; t++) begin
      wr(ARF_ADDR_CTRL_THREE, 8'h20 | 8'(t));
      wr(ARF_ADDR_STATUS, 8'h00);
      conv(16'h0000);
      chk(16'(tif), 16'(exp_t[t]));
    end
    rd16(ARF_ADDR_ERR_LOW);
    chk(rd_w, 16'hfff8);
    rd16(ARF_ADDR_ACC_LOW);
    chk(rd_w, 16'h0000);
    conv(16'h0020);
    rd(ARF_ADDR_STATUS);
    chk(16'(rd_q[2:1]), 16'h0002);
    $display("threshold test done");
  endtask

  task automatic t_avg;
    wr(ARF_ADDR_REPEAT, 8'h03);
    wr(ARF_ADDR_CTRL_THREE, 8'h07);
    wr(ARF_ADDR_CTRL_TWO, 8'h82);
    wr(ARF_ADDR_STATUS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      conv(16'h0004);
      chk(16'(tif), 16'(i == 2));
    end
    rd16(ARF_ADDR_FLT_LOW);
    chk(rd_w, 16'h000c);
    $display("average test done");
  endtask

  task automatic t_burst;
    int base;
    wr(ARF_ADDR_REPEAT, 8'h02);
    wr(ARF_ADDR_CTRL_TWO, 8'h83);
    base = retrig_n;
    conv(16'h0001);
    repeat (20) @(posedge clk);
    rd(ARF_ADDR_COUNT);
    chk(16'(rd_q), 16'h0002);
    chk(16'(retrig_n - base), 16'h0001);
    $display("burst test done");
  endtask

  task automatic t_rc_clear;
    on_rc <= 1'b1;
    wr(ARF_ADDR_CTRL_TWO, 8'h83);
    for (int i = 1; i <= 5; i++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      rd(ARF_ADDR_STATUS);
      chk(16'(rd_q[ARF_STAT_CLRBUSY_BIT]), 16'(i < 5));
    end
    rd16(ARF_ADDR_ACC_LOW);
    chk(rd_w, 16'h0000);
    on_rc <= 1'b0;
    $display("rc clock clear test done");
  endtask

  // low-pass, cvd error select and an undefined mode code; filtered starts at 2 after burst
  task automatic t_lpf_modes;
    wr(ARF_ADDR_CTRL_THREE, 8'h60);
    wr(ARF_ADDR_CTRL_TWO, 8'h94);
    conv(16'h0022);
    conv(16'h0012);
    rd16(ARF_ADDR_FLT_LOW);
    chk(rd_w, 16'h0012);
    rd16(ARF_ADDR_ERR_LOW);
    chk(rd_w, 16'h000a);
    wr(ARF_ADDR_CTRL_THREE, 8'h10);
    cvd_result <= 16'h1234;
    conv(16'h0001);
    rd16(ARF_ADDR_ERR_LOW);
    chk(rd_w, 16'h1234);
    wr(ARF_ADDR_CTRL_TWO, 8'h07);
    conv(16'h0100);
    rd16(ARF_ADDR_ACC_LOW);
    chk(rd_w, 16'h0035);
    $display("low-pass and mode code test done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_accum();
    t_ovf_clear();
    wr(ARF_ADDR_STATUS, 8'h00);
    t_thresh();
    t_avg();
    t_burst();
    t_rc_clear();
    t_lpf_modes();
    finish_test();
  end
endmodule // tb_adc_result_filter_threshold
